// *** include/tcc_pkg.sv ***
// Shared constants, modes and decode for the timer channel block
package tcc_pkg;

  // ==========================================
  // Register byte addresses
  localparam logic [7:0] SC0_OFS = 8'h00;
  localparam logic [7:0] HI0_OFS = 8'h04;
  localparam logic [7:0] LO0_OFS = 8'h08;
  localparam logic [7:0] SC1_OFS = 8'h0c;
  localparam logic [7:0] HI1_OFS = 8'h10;
  localparam logic [7:0] LO1_OFS = 8'h14;

  // ==========================================
  // Status and control field positions
  localparam int FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int BUF_BIT = 5;
  localparam int MSA_BIT = 4;
  localparam int ELS_HI_BIT = 3;
  localparam int ELS_LO_BIT = 2;
  localparam int TOV_BIT = 1;
  localparam int MAX_BIT = 0;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // ==========================================
  // Edge/level field codes
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  typedef enum logic [1:0] {
    TCC_PRESET,
    TCC_CAPTURE,
    TCC_COMPARE,
    TCC_BUFFERED
  } tcc_mode_type;

  // Channel function from buffered bit, mode bit A and edge field
  function automatic tcc_mode_type tcc_decode(input logic [6:0] ctrl);
    if (ctrl[ELS_HI_BIT:ELS_LO_BIT] == ELS_OFF) begin
      return TCC_PRESET;
    end else if (ctrl[BUF_BIT]) begin
      return TCC_BUFFERED;
    end else if (ctrl[MSA_BIT]) begin
      return TCC_COMPARE;
    end else begin
      return TCC_CAPTURE;
    end
  endfunction : tcc_decode

endpackage : tcc_pkg

// *** src/tcc_edge_det.sv ***
// Active edge detector for one capture channel
`timescale 1ns/10ps
`default_nettype none
module tcc_edge_det (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pin and edge field
  input wire logic pin_i,
  input wire logic [1:0] els_i,
  // Edge pulse
  output logic edge_o
);

  logic prev_r;
  logic edge_r;
  logic rise;
  logic fall;

  assign rise = pin_i && !prev_r;
  assign fall = !pin_i && prev_r;
  assign edge_o = edge_r;

  // ==========================================
  // Edge sensing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_r <= 1'h0;
    end else begin
      prev_r <= pin_i;
    end
  end

  // Low code bit picks rising, high code bit picks falling
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_r <= 1'h0;
    end else begin
      edge_r <= (els_i[0] && rise) || (els_i[1] && fall);
    end
  end

  rise_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    els_i == tcc_pkg::EDGE_RISE && fall |=> !edge_o)
    else $error("falling edge seen with rising-only select");

  fall_seen_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    els_i[1] && fall |=> edge_o)
    else $error("falling edge missed");

endmodule : tcc_edge_det
`default_nettype wire

// *** src/tcc_pin_ctrl.sv ***
// Output level and drive control for one channel pin
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Channel setup
  input wire tcc_pkg::tcc_mode_type mode_i,
  input wire logic msa_i,
  input wire logic [1:0] els_i,
  input wire logic tov_i,
  input wire logic max_i,
  // Timer events
  input wire logic match_i,
  input wire logic ovf_i,
  // Pin
  output logic pin_o,
  output logic oe_o
);

  logic out_r;
  logic max_eff_r;
  logic drive;
  logic max_nxt;

  assign drive = (mode_i == tcc_pkg::TCC_COMPARE) || (mode_i == tcc_pkg::TCC_BUFFERED);
  assign max_nxt = drive && tov_i && max_i && (els_i == tcc_pkg::ACT_CLEAR);
  assign pin_o = out_r;
  assign oe_o = drive;

  // ==========================================
  // Full duty is sampled only at overflow, so it starts at the next overflow
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      max_eff_r <= 1'h0;
    end else if (!drive) begin
      max_eff_r <= 1'h0;
    end else if (ovf_i) begin
      max_eff_r <= max_nxt;
    end
  end

  // ==========================================
  // Output level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_r <= 1'h1;
    end else if (mode_i == tcc_pkg::TCC_PRESET) begin
      out_r <= !msa_i;
    end else if (drive && tov_i && ovf_i) begin
      out_r <= max_nxt || max_eff_r || !out_r;
    end else if (drive && match_i) begin
      case (els_i)
        tcc_pkg::ACT_TOGGLE: out_r <= !out_r;
        tcc_pkg::ACT_CLEAR: out_r <= max_eff_r;
        tcc_pkg::ACT_SET: out_r <= 1'h1;
        default: out_r <= out_r;
      endcase
    end
  end

  sequence max_arm_s;
    ovf_i && max_nxt ##1 drive && els_i == tcc_pkg::ACT_CLEAR;
  endsequence

  preset_lvl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_i == tcc_pkg::TCC_PRESET |=> out_r == !$past(msa_i))
    else $error("preset level wrong");

  port_ctrl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    els_i == tcc_pkg::ELS_OFF |-> !oe_o)
    else $error("pin driven while disconnected");

  cap_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_i == tcc_pkg::TCC_CAPTURE && ovf_i && tov_i |=> $stable(out_r))
    else $error("overflow toggled a capture pin");

  ovf_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    drive && tov_i && ovf_i && match_i && els_i == tcc_pkg::ACT_SET
    && out_r && !max_nxt && !max_eff_r |=> !out_r)
    else $error("compare beat overflow");

  set_act_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    drive && match_i && !(tov_i && ovf_i) && els_i == tcc_pkg::ACT_SET |=> out_r)
    else $error("set on compare failed");

  full_duty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    max_arm_s |=> out_r)
    else $error("full duty not forced");

  zero_duty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    drive && !tov_i && !max_eff_r && els_i == tcc_pkg::ACT_CLEAR && !out_r |=> !out_r)
    else $error("zero duty output rose");

endmodule : tcc_pin_ctrl
`default_nettype wire

// *** src/tcc_top.sv ***
// Two-channel timer capture/compare block with APB register access
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Only channel 0 keeps the buffered-mode bit; it enables buffered compare/PWM.
// - Pair link set: channel 1 control register dead, its pin returns to port.
// - With edge field nonzero, mode bit A picks compare (1) or capture (0).
// - With edge field zero, mode bit A gives preset level: 1 low, 0 high.
// - Edge field zero leaves the pin to the port; channel holds its preset.
// - Capture edges: 01 rising, 10 falling, 11 both.
// - Compare action: 00 none, 01 toggle, 10 clear, 11 set; same when buffered.
// - Reset clears buffered, mode A, edge field and overflow toggle bits.
// - Overflow toggle flips a compare pin each overflow; no effect in capture.
// - Overflow action wins over a simultaneous compare when toggle is on.
// - Full-duty bit forces output high from next period, with toggle and clear.
// - Clear on compare, no toggle and no full duty give a low output.
// - Value pair holds capture or compare value; undefined after reset.
// - In capture mode a high-byte read blocks captures until the low read.
// - In compare modes a high-byte write blocks compares until the low write.
// - Flag sets on capture or match; read set then write 0 clears it.
module tcc_top (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Counter
  input wire logic [15:0] COUNT_I,
  input wire logic COUNT_TICK_I,
  input wire logic OVERFLOW_I,
  input wire logic COUNTER_HALT_I,
  // Channel pins
  input wire logic [1:0] CHANNEL_PIN_I,
  output logic [1:0] CHANNEL_PIN_O,
  output logic [1:0] CHANNEL_PIN_OE_O
);

  localparam int NCH = 2;

  logic [6:0] ctrl_r [NCH];
  logic [15:0] val_r [NCH];
  logic [NCH-1:0] flag_r;
  logic [NCH-1:0] arm_r;
  logic [NCH-1:0] rlock_r;
  logic [NCH-1:0] wlock_r;
  logic last_r;
  logic act_r;
  logic [31:0] prdata_r;
  logic access;
  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic linked;
  logic [NCH-1:0] hit_sc;
  logic [NCH-1:0] hit_hi;
  logic [NCH-1:0] hit_lo;
  logic [NCH-1:0] sc_dis;
  logic [NCH-1:0] cmp_en;
  logic [NCH-1:0] wl_en;
  logic [NCH-1:0] edge_w;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] match;
  logic [NCH-1:0] ev;
  logic [6:0] eff_w [NCH];
  logic [15:0] cmp_val [NCH];
  tcc_pkg::tcc_mode_type mode_w [NCH];
  logic [7:0] rd_byte;

  // ==========================================
  // APB handshake
  // One setup cycle gives time to register read data
  assign access = PSEL_I && PENABLE_I;
  assign setup = PSEL_I && !PENABLE_I;
  assign wr = access && PWRITE_I;
  assign rd = access && !PWRITE_I;
  assign PREADY_O = access;
  assign PSLVERR_O = access && !mapped;
  assign PRDATA_O = prdata_r;

  always_comb begin
    hit_sc = '0;
    hit_hi = '0;
    hit_lo = '0;
    mapped = 1'h1;
    if (PADDR_I == tcc_pkg::SC0_OFS) begin
      hit_sc[0] = 1'h1;
    end else if (PADDR_I == tcc_pkg::HI0_OFS) begin
      hit_hi[0] = 1'h1;
    end else if (PADDR_I == tcc_pkg::LO0_OFS) begin
      hit_lo[0] = 1'h1;
    end else if (PADDR_I == tcc_pkg::SC1_OFS) begin
      hit_sc[1] = 1'h1;
    end else if (PADDR_I == tcc_pkg::HI1_OFS) begin
      hit_hi[1] = 1'h1;
    end else if (PADDR_I == tcc_pkg::LO1_OFS) begin
      hit_lo[1] = 1'h1;
    end else begin
      mapped = 1'h0;
    end
  end

  // ==========================================
  // Channel setup as seen by the logic
  assign linked = ctrl_r[0][tcc_pkg::BUF_BIT];
  assign sc_dis = {linked, 1'h0};

  always_comb begin
    eff_w[0] = ctrl_r[0];
    eff_w[1] = linked ? 7'h00 : ctrl_r[1];
    for (int ch = 0; ch < NCH; ch++) begin
      mode_w[ch] = tcc_pkg::tcc_decode(eff_w[ch]);
      cmp_en[ch] = eff_w[ch][tcc_pkg::BUF_BIT] || eff_w[ch][tcc_pkg::MSA_BIT];
    end
  end

  assign wl_en = {cmp_en[1] || linked, cmp_en[0]};
  assign cmp_val[0] = (linked && act_r) ? val_r[1] : val_r[0];
  assign cmp_val[1] = val_r[1];

  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      cap_ev[ch] = (mode_w[ch] == tcc_pkg::TCC_CAPTURE) && edge_w[ch] && !COUNTER_HALT_I;
    end
    match[0] = COUNT_TICK_I && (COUNT_I == cmp_val[0]) && cmp_en[0]
      && !((linked && act_r) ? wlock_r[1] : wlock_r[0]);
    match[1] = COUNT_TICK_I && (COUNT_I == cmp_val[1]) && cmp_en[1] && !wlock_r[1];
  end

  assign ev = cap_ev | match;

  // ==========================================
  // Read data
  always_comb begin
    rd_byte = 8'h00;
    for (int ch = 0; ch < NCH; ch++) begin
      if (hit_sc[ch] && !sc_dis[ch]) begin
        rd_byte = {flag_r[ch], ctrl_r[ch]};
      end else if (hit_hi[ch]) begin
        rd_byte = val_r[ch][15:8];
      end else if (hit_lo[ch]) begin
        rd_byte = val_r[ch][7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================
  // Control bits
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_r[0] <= tcc_pkg::CTRL_RESET;
      ctrl_r[1] <= tcc_pkg::CTRL_RESET;
    end else begin
      if (wr && hit_sc[0]) begin
        ctrl_r[0] <= PWDATA_I[6:0];
      end
      if (wr && hit_sc[1] && !linked) begin
        ctrl_r[1] <= PWDATA_I[6:0] & ~(7'h01 << tcc_pkg::BUF_BIT);
      end
    end
  end

  // ==========================================
  // Event flags: a new event beats the clear and disarms it
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flag_r <= '0;
      arm_r <= '0;
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (ev[ch]) begin
          flag_r[ch] <= 1'h1;
          arm_r[ch] <= 1'h0;
        end else if (wr && hit_sc[ch] && !sc_dis[ch]) begin
          if (arm_r[ch] && !PWDATA_I[tcc_pkg::FLAG_BIT]) begin
            flag_r[ch] <= 1'h0;
          end
          arm_r[ch] <= 1'h0;
        end else if (rd && hit_sc[ch] && !sc_dis[ch] && flag_r[ch]) begin
          arm_r[ch] <= 1'h1;
        end
      end
    end
  end

  // ==========================================
  // Two-byte coherency locks
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rlock_r <= '0;
      wlock_r <= '0;
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (rd && hit_lo[ch]) begin
          rlock_r[ch] <= 1'h0;
        end else if (rd && hit_hi[ch] && mode_w[ch] == tcc_pkg::TCC_CAPTURE) begin
          rlock_r[ch] <= 1'h1;
        end
        if (wr && hit_lo[ch]) begin
          wlock_r[ch] <= 1'h0;
        end else if (wr && hit_hi[ch] && wl_en[ch]) begin
          wlock_r[ch] <= 1'h1;
        end
      end
    end
  end

  // ==========================================
  // Value pairs carry no reset; software must load them before use
  always_ff @(posedge REF_CLK_I) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (wr && hit_hi[ch]) begin
        val_r[ch][15:8] <= PWDATA_I[7:0];
      end else if (wr && hit_lo[ch]) begin
        val_r[ch][7:0] <= PWDATA_I[7:0];
      end else if (cap_ev[ch] && !rlock_r[ch]) begin
        val_r[ch] <= COUNT_I;
      end
    end
  end

  // ==========================================
  // Buffered pair selection
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      last_r <= 1'h0;
      act_r <= 1'h0;
    end else if (!linked) begin
      last_r <= 1'h0;
      act_r <= 1'h0;
    end else begin
      if (wr && hit_lo[0]) begin
        last_r <= 1'h0;
      end else if (wr && hit_lo[1]) begin
        last_r <= 1'h1;
      end
      if (OVERFLOW_I) begin
        act_r <= last_r;
      end
    end
  end

  // ==========================================
  // Per-channel edge and pin logic
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    tcc_edge_det u_edge (
      .clk_i(REF_CLK_I),
      .rst_n_i(ARST_N_I),
      .pin_i(CHANNEL_PIN_I[ch]),
      .els_i(eff_w[ch][tcc_pkg::ELS_HI_BIT:tcc_pkg::ELS_LO_BIT]),
      .edge_o(edge_w[ch])
    );
    tcc_pin_ctrl u_pin (
      .clk_i(REF_CLK_I),
      .rst_n_i(ARST_N_I),
      .mode_i(mode_w[ch]),
      .msa_i(eff_w[ch][tcc_pkg::MSA_BIT]),
      .els_i(eff_w[ch][tcc_pkg::ELS_HI_BIT:tcc_pkg::ELS_LO_BIT]),
      .tov_i(eff_w[ch][tcc_pkg::TOV_BIT]),
      .max_i(eff_w[ch][tcc_pkg::MAX_BIT]),
      .match_i(match[ch]),
      .ovf_i(OVERFLOW_I),
      .pin_o(CHANNEL_PIN_O[ch]),
      .oe_o(CHANNEL_PIN_OE_O[ch])
    );
  end

  // ==========================================
  // Checks
  sequence sc0_rd_set_s;
    rd && hit_sc[0] && flag_r[0];
  endsequence

  sequence sc0_wr_zero_s;
    wr && hit_sc[0] && !PWDATA_I[tcc_pkg::FLAG_BIT] && !ev[0];
  endsequence

  buf1_zero_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    !ctrl_r[1][tcc_pkg::BUF_BIT])
    else $error("channel 1 holds a buffered bit");

  link_off_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    linked |-> !CHANNEL_PIN_OE_O[1] && !flag_r[1] || $past(!linked))
    else $error("channel 1 active while linked");

  cap_copy_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    cap_ev[0] && !rlock_r[0] && !(wr && (hit_hi[0] || hit_lo[0]))
    |=> val_r[0] == $past(COUNT_I))
    else $error("capture value not copied");

  rd_lock_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    rlock_r[0] && !wr |=> $stable(val_r[0]))
    else $error("capture during high-byte lock");

  wr_lock_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    wlock_r[0] && !linked && !cap_ev[0] |-> !ev[0])
    else $error("compare during high-byte write lock");

  flag_clr_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    sc0_rd_set_s ##1 (!ev[0] && !(wr && hit_sc[0]))[*2] ##1 sc0_wr_zero_s |=> !flag_r[0])
    else $error("flag clear sequence failed");

  one_wr_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    flag_r[0] && wr && hit_sc[0] && PWDATA_I[tcc_pkg::FLAG_BIT] |=> flag_r[0])
    else $error("writing one cleared the flag");

  buf_swap_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    linked && OVERFLOW_I ##1 linked |-> act_r == $past(last_r))
    else $error("buffered pair not swapped at overflow");

endmodule : tcc_top
`default_nettype wire

// *** tb/tcc_pin_agent.sv ***
// Model of the outside signals that meet the two channel pins
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_agent (
  // Levels the outside source wants on the pins
  input wire logic [1:0] drive_i,
  // Channel side of the pins
  input wire logic [1:0] chan_out_i,
  input wire logic [1:0] chan_oe_i,
  // Level seen on each pin
  output logic [1:0] level_o
);
  // ==========================================
  // Pin resolution
  // Channel level wins over the source while the channel drives, so no contention
  // Source only changes after capture is switched on
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      level_o[i] = chan_oe_i[i] ? chan_out_i[i] : drive_i[i];
    end
  end
endmodule : tcc_pin_agent
`default_nettype wire

// *** tb/tcc_top_bench.sv ***
// Self-checking bench for the timer channel block
`timescale 1ns/10ps
`default_nettype none
module tcc_top_bench;
  // ==========================================
  // Signals
  localparam logic [7:0] ACTS = 8'hb5;
  localparam logic [3:0] PEXP = 4'h5;
  logic clk;
  logic arst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] count;
  logic tick;
  logic ovf;
  logic halt;
  logic [1:0] drv;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [31:0] rdv;
  logic slv;
  int err_total;
  int checks;

  // ==========================================
  // Clock, design and pin model
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  tcc_top dut (
    .REF_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .COUNT_I(count), .COUNT_TICK_I(tick),
    .OVERFLOW_I(ovf), .COUNTER_HALT_I(halt), .CHANNEL_PIN_I(pin_in),
    .CHANNEL_PIN_O(pin_out), .CHANNEL_PIN_OE_O(pin_oe)
  );

  tcc_pin_agent pins (.drive_i(drv), .chan_out_i(pin_out), .chan_oe_i(pin_oe), .level_o(pin_in));

  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdv, {24'h000000, e});
  endtask : rdc

  // Counter held stopped and cleared around every mode change
  task automatic mode(input logic [7:0] a, input logic [7:0] d);
    halt <= 1'b1;
    count <= 16'h0000;
    wr(a, d);
    halt <= 1'b0;
  endtask : mode

  task automatic ev(input logic [15:0] v, input logic t, input logic o);
    @(posedge clk);
    count <= v;
    tick <= t;
    ovf <= o;
    @(posedge clk);
    tick <= 1'b0;
    ovf <= 1'b0;
    @(negedge clk);
  endtask : ev

  task automatic pinset(input logic [15:0] v, input logic l);
    @(posedge clk);
    count <= v;
    drv[0] <= l;
    repeat (3) @(posedge clk);
  endtask : pinset

  task automatic capchk(input logic [15:0] e);
    logic [7:0] hi;
    apb(1'b0, tcc_pkg::HI0_OFS, 8'h00);
    hi = rdv[7:0];
    apb(1'b0, tcc_pkg::LO0_OFS, 8'h00);
    chk({16'h0000, hi, rdv[7:0]}, {16'h0000, e});
  endtask : capchk

  // Pin flop moves one edge after the setting that drives it
  task automatic pin0(input logic e);
    @(posedge clk);
    @(negedge clk);
    chk({31'h0, pin_out[0]}, {31'h0, e});
  endtask : pin0

  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // ==========================================
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #3000000;
    err_total++;
    give_verdict();
  end

  // ==========================================
  // Tests
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    count = 16'h0000;
    tick = 1'b0;
    ovf = 1'b0;
    halt = 1'b0;
    drv = 2'h0;
    err_total = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rdc(tcc_pkg::SC0_OFS, 8'h00);
    rdc(tcc_pkg::SC1_OFS, 8'h00);
    chk({30'h0, pin_oe}, 32'h0);
    apb(1'b0, 8'h18, 8'h00);
    chk({slv, rdv[30:0]}, 32'h80000000);
    // Capture on every edge code; pin idle low for ages first
    for (int e = 1; e < 4; e++) begin
      mode(tcc_pkg::SC0_OFS, 8'(e * 4));
      wr(tcc_pkg::HI0_OFS, 8'h00);
      wr(tcc_pkg::LO0_OFS, 8'h00);
      pinset({8'h11, 8'(e)}, 1'b1);
      capchk((e % 2 == 1) ? {8'h11, 8'(e)} : 16'h0000);
      pinset({8'h22, 8'(e)}, 1'b0);
      capchk((e > 1) ? {8'h22, 8'(e)} : {8'h11, 8'(e)});
    end
    rdc(tcc_pkg::SC0_OFS, 8'h8c);
    wr(tcc_pkg::SC0_OFS, 8'h8c);
    rdc(tcc_pkg::SC0_OFS, 8'h8c);
    wr(tcc_pkg::SC0_OFS, 8'h04);
    rdc(tcc_pkg::SC0_OFS, 8'h04);
    // High-byte read holds off a capture until the low read
    apb(1'b0, tcc_pkg::HI0_OFS, 8'h00);
    pinset(16'h5566, 1'b1);
    apb(1'b0, tcc_pkg::LO0_OFS, 8'h00);
    capchk(16'h2203);
    pinset(16'h0000, 1'b0);
    pinset(16'h7788, 1'b1);
    capchk(16'h7788);
    // Compare actions from a low preset
    mode(tcc_pkg::SC0_OFS, 8'h10);
    pin0(1'b0);
    chk({31'h0, pin_oe[0]}, 32'h0);
    wr(tcc_pkg::HI0_OFS, 8'h00);
    wr(tcc_pkg::LO0_OFS, 8'h40);
    for (int i = 0; i < 4; i++) begin
      mode(tcc_pkg::SC0_OFS, {4'h1, ACTS[2 * i +: 2], 2'h0});
      ev(16'h0040, 1'b1, 1'b0);
      pin0(PEXP[i]);
    end
    chk({31'h0, pin_oe[0]}, 32'h1);
    rdc(tcc_pkg::SC0_OFS, 8'h98);
    wr(tcc_pkg::SC0_OFS, 8'h1c);
    wr(tcc_pkg::HI0_OFS, 8'h00);
    ev(16'h0040, 1'b1, 1'b0);
    pin0(1'b0);
    rdc(tcc_pkg::SC0_OFS, 8'h1c);
    wr(tcc_pkg::LO0_OFS, 8'h40);
    ev(16'h0040, 1'b1, 1'b0);
    pin0(1'b1);
    rdc(tcc_pkg::SC0_OFS, 8'h9c);
    // Overflow toggle, its priority, full and zero duty
    mode(tcc_pkg::SC0_OFS, 8'h1a);
    ev(16'h0000, 1'b0, 1'b1);
    pin0(1'b0);
    ev(16'h0040, 1'b1, 1'b1);
    pin0(1'b1);
    ev(16'h0040, 1'b1, 1'b0);
    pin0(1'b0);
    mode(tcc_pkg::SC0_OFS, 8'h1b);
    ev(16'h0000, 1'b0, 1'b1);
    pin0(1'b1);
    ev(16'h0040, 1'b1, 1'b0);
    pin0(1'b1);
    mode(tcc_pkg::SC0_OFS, 8'h1a);
    ev(16'h0000, 1'b0, 1'b1);
    pin0(1'b1);
    ev(16'h0040, 1'b1, 1'b0);
    pin0(1'b0);
    mode(tcc_pkg::SC0_OFS, 8'h18);
    ev(16'h0000, 1'b0, 1'b1);
    pin0(1'b0);
    // Buffered bit on channel 0 only, and the pair link
    mode(tcc_pkg::SC1_OFS, 8'h34);
    rdc(tcc_pkg::SC1_OFS, 8'h14);
    chk({31'h0, pin_oe[1]}, 32'h1);
    // Channel 1 toggles from its high preset; flag cleared before the link hides it
    wr(tcc_pkg::HI1_OFS, 8'h00);
    wr(tcc_pkg::LO1_OFS, 8'h30);
    ev(16'h0030, 1'b1, 1'b0);
    chk({31'h0, pin_out[1]}, 32'h0);
    rdc(tcc_pkg::SC1_OFS, 8'h94);
    wr(tcc_pkg::SC1_OFS, 8'h14);
    rdc(tcc_pkg::SC1_OFS, 8'h14);
    mode(tcc_pkg::SC0_OFS, 8'h20);
    rdc(tcc_pkg::SC0_OFS, 8'ha0);
    chk({31'h0, pin_oe[1]}, 32'h0);
    rdc(tcc_pkg::SC1_OFS, 8'h00);
    mode(tcc_pkg::SC1_OFS, 8'h14);
    rdc(tcc_pkg::SC1_OFS, 8'h00);
    // Last written pair takes over at overflow
    mode(tcc_pkg::SC0_OFS, 8'h30);
    pin0(1'b0);
    wr(tcc_pkg::HI0_OFS, 8'h00);
    wr(tcc_pkg::LO0_OFS, 8'h10);
    wr(tcc_pkg::HI1_OFS, 8'h00);
    wr(tcc_pkg::LO1_OFS, 8'h20);
    mode(tcc_pkg::SC0_OFS, 8'h2c);
    ev(16'h0000, 1'b0, 1'b1);
    ev(16'h0010, 1'b1, 1'b0);
    pin0(1'b0);
    ev(16'h0020, 1'b1, 1'b0);
    pin0(1'b1);
    give_verdict();
  end
endmodule : tcc_top_bench
`default_nettype wire
